//--- cdio_pkg.sv
package cdio_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SCAN_PERIOD_MS = 1000;
  localparam int unsigned SCAN_CYCLES   = (CLK_HZ / 1000) * SCAN_PERIOD_MS;
  localparam int unsigned PCT_FULL      = 100;
  localparam int unsigned PCT_ZERO      = 0;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_REQ     = 12'h004;
  localparam logic [11:0] OFS_SLIDE   = 12'h008;
  localparam logic [11:0] OFS_TEMP    = 12'h00C;
  localparam logic [11:0] OFS_SETPT   = 12'h010;
  localparam logic [11:0] OFS_INJ     = 12'h014;
  localparam logic [11:0] OFS_COND    = 12'h018;
  localparam logic [11:0] OFS_STATUS  = 12'h01C;
  localparam logic [11:0] OFS_OUTS    = 12'h020;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int unsigned CTRL_RUN_CMD   = 0;
  localparam int unsigned CTRL_PUMP_CMD  = 1;
  localparam int unsigned CTRL_TRIP      = 2;
  localparam int unsigned CTRL_ALARM     = 3;
  localparam int unsigned CTRL_REM_EN    = 4;
  localparam int unsigned CTRL_START_OK  = 5;
  localparam int unsigned CTRL_MAN_STOP  = 6;
  localparam int unsigned CTRL_INJ_MODE  = 7;
  localparam int unsigned CTRL_DUAL_INJ  = 8;
  localparam int unsigned CTRL_SHUNT_EN  = 9;
  localparam int unsigned CTRL_TRIP_CLR  = 10;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Status register fields
  localparam int unsigned ST_HL_TRIP   = 0;
  localparam int unsigned ST_OIL1_TRIP = 1;
  localparam int unsigned ST_OIL2_TRIP = 2;
  localparam int unsigned ST_REM_START = 3;
  localparam int unsigned ST_AUX_FB    = 4;
  localparam int unsigned ST_MISMATCH  = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic starter_aux;
    logic high_level_ok;
    logic oil_float1_ok;
    logic oil_float2_ok;
    logic remote_select;
    logic remote_start;
    logic remote_raise;
    logic remote_lower;
  } cdio_in_t;

  typedef struct packed {
    logic comp_start;
    logic oil_pump;
    logic cap_raise;
    logic cap_lower;
    logic vri_raise;
    logic vri_lower;
    logic sump_heater;
    logic trip_ok;
    logic slide_sp1;
    logic slide_sp2;
    logic alarm_ok;
    logic econ_port2;
    logic liq_inj1;
    logic liq_inj2;
    logic remote_enabled;
    logic shunt_trip;
  } cdio_out_t;

  typedef enum logic [0:0] {
    CDIO_INJ_SOLENOID = 1'b0,
    CDIO_INJ_MOTOR    = 1'b1
  } cdio_inj_mode_t;

endpackage

//--- cdio_top.sv
// Function
// R1 - Start output follows the compressor run command.
// R2 - Oil pump output follows the oil pump run command.
// R3 - Capacity raise only while running, requested, and slide below 100%.
// R4 - Capacity lower only while running, requested, and slide above 0%.
// R5 - Volume ratio raise/lower only while running; blocked at 100% / 0%.
// R6 - Sump heater on while separator temperature below its setpoint.
// R7 - Trip indicator on with no trip; off until trip clears.
// R8 - Alarm indicator on with no alarm; off until alarm clears.
// R9 - Slide setpoint outputs on when slide at or above own setpoint.
// R10 - Economizer port two on when slide at or above its setpoint.
// R11 - Solenoid injection: on when discharge and separator above setpoints.
// R12 - Motor valve injection: hysteresis on discharge, separator override release; code sets on discharge above sep_ovr, not inj_sp1.
// R13 - Dual injection: second output from liquid pressure and slide.
// R14 - Remote enabled while remote accepted, start ok, no manual stop.
// R15 - Shunt trip when motor runs without a run command.
// R16 - Starter drives auxiliary contact to confirm energized.
// R17 - High level input must be active; loss stops and trips.
// R18 - Each oil float must be active; loss stops, trips separately.
// R19 - Remote select gates remote raise and lower inputs.
// R20 - Remote start/stop requests start if available, stops when low.
// R21 - Remote raise/lower sampled once per second; partner holds them.
// R22 - Remote raise/lower move slide only while running, until released.
// R23 - All outputs deasserted in reset until first evaluation.
`timescale 1ns/100ps
`default_nettype none

module cdio_top
  import cdio_pkg::*;
#(
  parameter int unsigned SCAN_CYC = SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Field inputs
  input  wire cdio_in_t    field_in,
  // Field outputs
  output cdio_out_t        field_out
);

  // Elaboration check: a zero scan period would never tick
  if (SCAN_CYC < 1) begin : g_scan_chk
    $error("SCAN_CYC must be at least one");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] req_reg;
  logic [31:0] slide_reg;
  logic [31:0] temp_reg;
  logic [31:0] setpt_reg;
  logic [31:0] inj_reg;
  logic [31:0] cond_reg;
  logic [2:0]  trip_reg;
  logic [31:0] scan_cnt_reg;
  logic        rem_raise_reg;
  logic        rem_lower_reg;
  logic        eval_reg;
  logic        inj1_hold_reg;
  cdio_out_t   out_reg;
  cdio_out_t   out_next;

  // ****************************************
  // APB decode
  // ****************************************
  wire         acc      = psel & penable;
  wire         wr       = acc & pwrite;
  wire         hit_ctrl = (paddr == OFS_CTRL);
  wire         hit_req  = (paddr == OFS_REQ);
  wire         hit_sld  = (paddr == OFS_SLIDE);
  wire         hit_tmp  = (paddr == OFS_TEMP);
  wire         hit_sp   = (paddr == OFS_SETPT);
  wire         hit_inj  = (paddr == OFS_INJ);
  wire         hit_cnd  = (paddr == OFS_COND);
  wire         hit_st   = (paddr == OFS_STATUS);
  wire         hit_out  = (paddr == OFS_OUTS);
  wire         mapped   = hit_ctrl | hit_req | hit_sld | hit_tmp | hit_sp | hit_inj | hit_cnd
                          | hit_st | hit_out;
  wire  [31:0] bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ****************************************
  // Field decode
  // ****************************************
  // Slide register: [7:0] slide %, [15:8] volume %, [23:16] liquid pressure
  wire  [7:0]  slide_pct = slide_reg[7:0];
  wire  [7:0]  vol_pct   = slide_reg[15:8];
  wire  [7:0]  liq_pres  = slide_reg[23:16];
  // Temp register: [15:0] discharge, [31:16] separator
  wire  [15:0] t_dis     = temp_reg[15:0];
  wire  [15:0] t_sep     = temp_reg[31:16];
  // Setpoint register: [7:0] sp1, [15:8] sp2, [23:16] econ2, [31:24] inj2 slide
  wire  [7:0]  sp1       = setpt_reg[7:0];
  wire  [7:0]  sp2       = setpt_reg[15:8];
  wire  [7:0]  sp_econ2  = setpt_reg[23:16];
  wire  [7:0]  sp_inj2s  = setpt_reg[31:24];
  // Injection register: [15:0] inj sp1, [31:16] separator override
  wire  [15:0] inj_sp1   = inj_reg[15:0];
  wire  [15:0] sep_ovr   = inj_reg[31:16];
  // Cond register: [15:0] heater sp, [23:16] differential, [31:24] inj2 pressure
  wire  [15:0] heat_sp   = cond_reg[15:0];
  wire  [7:0]  inj_diff  = cond_reg[23:16];
  wire  [7:0]  inj2_pres = cond_reg[31:24];

  wire         run_cmd   = ctrl_reg[CTRL_RUN_CMD];
  wire         any_trip  = ctrl_reg[CTRL_TRIP] | (|trip_reg);
  wire         field_ok  = field_in.high_level_ok & field_in.oil_float1_ok
                           & field_in.oil_float2_ok;
  wire         remote_on = ctrl_reg[CTRL_REM_EN] & field_in.remote_select;              // R19
  wire         rem_start = remote_on & field_in.remote_start & ctrl_reg[CTRL_START_OK]; // R20
  wire         run_eff   = (run_cmd | rem_start) & field_ok & ~(|trip_reg)
                           & ~(remote_on & ~field_in.remote_start);                     // R20
  wire         running   = run_eff & field_in.starter_aux;                              // R16
  wire         scan_tick = (scan_cnt_reg == SCAN_CYC - 1);                              // R21
  wire  [16:0] dis_rel   = {1'b0, inj_sp1} - {9'h0_00, inj_diff};
  wire         inj_mode  = ctrl_reg[CTRL_INJ_MODE];

  // ****************************************
  // Output evaluation
  // ****************************************
  always_comb begin
    out_next                = '0;
    out_next.comp_start     = run_eff;                                                  // R1
    out_next.oil_pump       = ctrl_reg[CTRL_PUMP_CMD] & field_ok;                       // R2
    out_next.cap_raise      = running & (req_reg[0] | (remote_on & rem_raise_reg))
                              & (slide_pct < PCT_FULL[7:0]);                            // R3 R22
    out_next.cap_lower      = running & (req_reg[1] | (remote_on & rem_lower_reg))
                              & (slide_pct > PCT_ZERO[7:0]);                            // R4 R22
    out_next.vri_raise      = running & req_reg[2] & (vol_pct < PCT_FULL[7:0]);         // R5
    out_next.vri_lower      = running & req_reg[3] & (vol_pct > PCT_ZERO[7:0]);         // R5
    if (out_next.cap_raise && out_next.cap_lower) begin
      out_next.cap_lower = 1'b0;
    end
    if (out_next.vri_raise && out_next.vri_lower) begin
      out_next.vri_lower = 1'b0;
    end
    // Equal temperature holds the last state to avoid chatter
    if (t_sep < heat_sp) begin
      out_next.sump_heater = 1'b1;                                                      // R6
    end else if (t_sep > heat_sp) begin
      out_next.sump_heater = 1'b0;
    end else begin
      out_next.sump_heater = out_reg.sump_heater;
    end
    out_next.trip_ok        = ~any_trip;                                                // R7
    out_next.alarm_ok       = ~ctrl_reg[CTRL_ALARM];                                    // R8
    out_next.slide_sp1      = (slide_pct >= sp1);                                       // R9
    out_next.slide_sp2      = (slide_pct >= sp2);                                       // R9
    out_next.econ_port2     = (slide_pct >= sp_econ2);                                  // R10
    if (inj_mode == CDIO_INJ_SOLENOID) begin
      out_next.liq_inj1 = (t_dis > inj_sp1) & (t_sep > sep_ovr);                        // R11
    end else begin
      out_next.liq_inj1 = inj1_hold_reg;                                                // R12
    end
    out_next.liq_inj2       = ctrl_reg[CTRL_DUAL_INJ] & (liq_pres > inj2_pres)
                              & (slide_pct >= sp_inj2s);                                // R13
    out_next.remote_enabled = remote_on & ctrl_reg[CTRL_START_OK]
                              & ~ctrl_reg[CTRL_MAN_STOP];                               // R14
    out_next.shunt_trip     = ctrl_reg[CTRL_SHUNT_EN] & field_in.starter_aux & ~run_eff; // R15
  end

  // ****************************************
  // Injection hysteresis
  // ****************************************
  wire inj1_set = running & (t_dis > sep_ovr) & (t_sep > sep_ovr);
  wire inj1_rel = ({1'b0, t_dis} < dis_rel) | (t_sep < sep_ovr) | ~running;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj1_hold_reg <= 1'b0;
    end else if (inj1_set) begin
      inj1_hold_reg <= 1'b1;                                                            // R12
    end else if (inj1_rel) begin
      inj1_hold_reg <= 1'b0;                                                            // R12
    end
  end

  // ****************************************
  // Remote scan
  // ****************************************
  // Slow scan mirrors the controller's polling; short pulses can be missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_reg  <= '0;
      rem_raise_reg <= 1'b0;
      rem_lower_reg <= 1'b0;
    end else if (scan_tick) begin
      scan_cnt_reg  <= '0;
      rem_raise_reg <= field_in.remote_raise;                                           // R21
      rem_lower_reg <= field_in.remote_lower;                                           // R21
    end else begin
      scan_cnt_reg  <= scan_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************
  // Latched field trips
  // ****************************************
  wire [2:0] trip_set = {~field_in.oil_float2_ok, ~field_in.oil_float1_ok,
                         ~field_in.high_level_ok} & {3{eval_reg}};
  wire       trip_clr = wr & hit_ctrl & pstrb[1] & pwdata[CTRL_TRIP_CLR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_reg <= '0;
    end else if (trip_clr) begin
      trip_reg <= trip_set;                                                             // R17 R18
    end else begin
      trip_reg <= trip_reg | trip_set;                                                  // R17 R18
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= CTRL_RESET;
      req_reg   <= '0;
      slide_reg <= '0;
      temp_reg  <= '0;
      setpt_reg <= '0;
      inj_reg   <= '0;
      cond_reg  <= '0;
    end else if (wr) begin
      if (hit_ctrl) ctrl_reg  <= merge(ctrl_reg, pwdata, bmask) & ~(32'h0000_0001 << CTRL_TRIP_CLR);
      if (hit_req)  req_reg   <= merge(req_reg, pwdata, bmask);
      if (hit_sld)  slide_reg <= merge(slide_reg, pwdata, bmask);
      if (hit_tmp)  temp_reg  <= merge(temp_reg, pwdata, bmask);
      if (hit_sp)   setpt_reg <= merge(setpt_reg, pwdata, bmask);
      if (hit_inj)  inj_reg   <= merge(inj_reg, pwdata, bmask);
      if (hit_cnd)  cond_reg  <= merge(cond_reg, pwdata, bmask);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] status_word = {26'h000_0000, out_reg.shunt_trip, field_in.starter_aux,
                             rem_start, trip_reg[2], trip_reg[1], trip_reg[0]};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg  :
                       hit_req  ? req_reg   :
                       hit_sld  ? slide_reg :
                       hit_tmp  ? temp_reg  :
                       hit_sp   ? setpt_reg :
                       hit_inj  ? inj_reg   :
                       hit_cnd  ? cond_reg  :
                       hit_st   ? status_word :
                       hit_out  ? {16'h0000, out_reg} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  // Indicators stay low through reset so a dead board never reads as healthy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_reg  <= 1'b0;
      out_reg   <= '0;                                                                  // R23
    end else begin
      eval_reg  <= 1'b1;
      out_reg   <= eval_reg ? out_next : '0;                                            // R23
    end
  end

  assign field_out = out_reg;

endmodule // cdio_top

`default_nettype wire

//--- cdio_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module cdio_monitor
  import cdio_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Field side
  input wire cdio_in_t    field_in,
  input wire cdio_out_t   field_out
);
  // ****************************************
  // Checks
  // ****************************************
  logic [1:0] up_cnt;

  // Trips only latch once the first evaluation is over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end

  wire settled = (up_cnt == 2'h3);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_level_lost;
    settled && !field_in.high_level_ok;
  endsequence

  sequence s_float_lost;
    settled && (!field_in.oil_float1_ok || !field_in.oil_float2_ok);
  endsequence

  a_reset_quiet: assert property ($rose(presetn) |-> field_out == '0)
    else $error("outputs not quiet after reset");
  a_raise_run: assert property (field_out.cap_raise |->
    field_out.comp_start && $past(field_in.starter_aux) && !field_out.cap_lower)
    else $error("capacity raise while stopped");
  a_lower_run: assert property (field_out.cap_lower |-> field_out.comp_start)
    else $error("capacity lower while stopped");
  a_vri_run: assert property ((field_out.vri_raise || field_out.vri_lower) |->
    field_out.comp_start && !(field_out.vri_raise && field_out.vri_lower))
    else $error("volume move while stopped");
  a_level_stop: assert property (s_level_lost |-> ##[1:2] !field_out.comp_start)
    else $error("no stop on high level");
  a_float_stop: assert property (s_float_lost |->
    ##[1:2] (!field_out.comp_start && !field_out.trip_ok))
    else $error("no stop on oil float");
  a_trip_hold: assert property (settled && !field_out.trip_ok && !field_in.high_level_ok
    |=> !field_out.trip_ok)
    else $error("trip indicator back while trip stands");
  a_shunt_idle: assert property (field_out.shunt_trip |-> !field_out.comp_start)
    else $error("shunt trip while commanded to run");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer with data");
endmodule // cdio_monitor

bind cdio_top cdio_monitor u_cdio_monitor (
  .pclk     (pclk),
  .presetn  (presetn),
  .prdata   (prdata),
  .pready   (pready),
  .pslverr  (pslverr),
  .field_in (field_in),
  .field_out(field_out)
);

`default_nettype wire

//--- cdio_field_model.sv
`timescale 1ns/100ps
`default_nettype none

module cdio_field_model
  import cdio_pkg::*;
(
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Switch levels; starter_aux here means a welded contactor
  input  wire cdio_in_t  sw,
  // Device side
  input  wire cdio_out_t field_out,
  output cdio_in_t       field_in
);
  // ****************************************
  // Starter and breaker
  // ****************************************
  logic aux_reg;
  logic brk_reg;

  // Breaker stays open once tripped, like the real one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      brk_reg <= brk_reg | field_out.shunt_trip;
      aux_reg <= !brk_reg & (field_out.comp_start | sw.starter_aux);
    end
  end

  // Remote levels pass straight through; the bench holds them long enough
  assign field_in = {aux_reg, sw[6:0]};
endmodule // cdio_field_model

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import cdio_pkg::*;
  // ****************************************
  // Bench
  // ****************************************
  localparam int unsigned SCAN = 8;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  cdio_in_t    sw;
  cdio_in_t    field_in;
  cdio_out_t   field_out;
  logic [31:0] rdat;
  int          miscompares;
  int          num_checks;
  logic [3:0]  mreq [9] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h3};
  logic [15:0] mpos [9] = '{16'h3232, 16'h3264, 16'h3200, 16'h3232, 16'h6432,
                            16'h3232, 16'h0032, 16'h3232, 16'h3232};
  logic [3:0]  mexp [9] = '{4'h8, 4'h0, 4'h0, 4'h4, 4'h0, 4'h2, 4'h0, 4'h1, 4'h8};
  logic [7:0]  spos [5] = '{8'h27, 8'h28, 8'h3C, 8'h4F, 8'h50};
  logic [2:0]  sexp [5] = '{3'h0, 3'h4, 3'h6, 3'h6, 3'h7};
  logic [31:0] itmp [8] = '{32'h0096_00FA, 32'h0032_00FA, 32'h0096_0096, 32'h0096_00FA,
                            32'h0096_00BE, 32'h0096_0046, 32'h0096_00FA, 32'h0032_00FA};
  logic [0:7]  iexp = 8'h9A;

  always #25 pclk = ~pclk;

  cdio_top #(.SCAN_CYC(SCAN)) u_cdio_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .field_in(field_in),
    .field_out(field_out));

  cdio_field_model u_cdio_field_model (.pclk(pclk), .presetn(presetn), .sw(sw),
    .field_out(field_out), .field_in(field_in));

  task test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task hold(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Held until pready at a rising edge; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    chk_bit("pslverr", a > OFS_OUTS, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task set_sw(input cdio_in_t v, input int n);
    @(posedge pclk);
    sw <= v;
    hold(n);
  endtask

  task t_reset;
    hold(1);
    chk_word("field_out", 32'h0000_0000, {16'h0000, field_out});
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk_word("ctrl", 32'h0000_0000, rdat);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk_word("unmapped", 32'h0000_0000, rdat);
  endtask

  task t_run;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    hold(6);
    chk_bit("comp_start", 1'b1, field_out.comp_start);
    chk_bit("oil_pump", 1'b1, field_out.oil_pump);
    chk_bit("trip_ok", 1'b1, field_out.trip_ok);
    chk_bit("alarm_ok", 1'b1, field_out.alarm_ok);
    apb(1'b1, OFS_CTRL, 32'h0000_000A);
    hold(6);
    chk_bit("comp_start", 1'b0, field_out.comp_start);
    chk_bit("oil_pump", 1'b1, field_out.oil_pump);
    chk_bit("alarm_ok", 1'b0, field_out.alarm_ok);
  endtask

  task t_moves;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, OFS_REQ, {28'h000_0000, mreq[i]});
      apb(1'b1, OFS_SLIDE, {16'h0000, mpos[i]});
      hold(6);
      chk_word("moves", {28'h000_0000, mexp[i]}, {28'h000_0000, field_out[13:10]});
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    hold(6);
    chk_bit("cap_raise", 1'b0, field_out.cap_raise);
  endtask

  task t_setpt;
    apb(1'b1, OFS_SETPT, 32'h3250_3C28);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_SLIDE, {24'h00_3200, spos[i]});
      hold(6);
      chk_word("slide_sp", {29'h0, sexp[i]},
               {29'h0, field_out.slide_sp1, field_out.slide_sp2, field_out.econ_port2});
    end
  endtask

  task t_heat_inj;
    apb(1'b1, OFS_COND, 32'h1E14_0064);
    apb(1'b1, OFS_TEMP, 32'h0032_0000);
    hold(6);
    chk_bit("sump_heater", 1'b1, field_out.sump_heater);
    apb(1'b1, OFS_INJ, 32'h0064_00C8);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CTRL, (i < 3) ? 32'h0000_0003 : 32'h0000_0083);
      apb(1'b1, OFS_TEMP, itmp[i]);
      hold(6);
      chk_bit("liq_inj1", iexp[i], field_out.liq_inj1);
      if (i == 6) begin
        chk_bit("sump_heater", 1'b0, field_out.sump_heater);
      end
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0103);
    apb(1'b1, OFS_SLIDE, 32'h0028_323C);
    hold(6);
    chk_bit("liq_inj2", 1'b1, field_out.liq_inj2);
    apb(1'b1, OFS_SLIDE, 32'h0014_323C);
    hold(6);
    chk_bit("liq_inj2", 1'b0, field_out.liq_inj2);
  endtask

  task t_trips;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_CTRL, 32'h0000_0003);
      set_sw(8'h70 & ~(8'h40 >> i), 6);
      chk_bit("comp_start", 1'b0, field_out.comp_start);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk_word("status", 32'h0000_0001 << i, {29'h0, rdat[2:0]});
      set_sw(8'h70, 6);
      chk_bit("trip_ok", 1'b0, field_out.trip_ok);
      apb(1'b1, OFS_CTRL, 32'h0000_0403);
      hold(6);
      chk_bit("trip_ok", 1'b1, field_out.trip_ok);
    end
  endtask

  // Raise and lower moves are held past two scan periods; start and select steps hold one
  task t_remote;
    apb(1'b1, OFS_CTRL, 32'h0000_0030);
    apb(1'b1, OFS_SLIDE, 32'h0000_3232);
    apb(1'b1, OFS_REQ, 32'h0000_0000);
    set_sw(8'h7C, 8);
    chk_bit("comp_start", 1'b1, field_out.comp_start);
    chk_bit("remote_enabled", 1'b1, field_out.remote_enabled);
    set_sw(8'h7E, 2 * SCAN + 6);
    chk_bit("cap_raise", 1'b1, field_out.cap_raise);
    set_sw(8'h7D, 2 * SCAN + 6);
    chk_bit("cap_raise", 1'b0, field_out.cap_raise);
    chk_bit("cap_lower", 1'b1, field_out.cap_lower);
    apb(1'b1, OFS_CTRL, 32'h0000_0070);
    hold(6);
    chk_bit("remote_enabled", 1'b0, field_out.remote_enabled);
    set_sw(8'h79, 8);
    chk_bit("comp_start", 1'b0, field_out.comp_start);
    // Local run command keeps it running, so only the select gate blocks lower
    apb(1'b1, OFS_CTRL, 32'h0000_0031);
    set_sw(8'h75, 8);
    chk_bit("comp_start", 1'b1, field_out.comp_start);
    chk_bit("cap_lower", 1'b0, field_out.cap_lower);
  endtask

  task t_shunt;
    int n;
    apb(1'b1, OFS_CTRL, 32'h0000_0200);
    set_sw(8'hF0, 0);
    n = 0;
    while (field_out.shunt_trip !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk_bit("shunt_trip", 1'b1, field_out.shunt_trip);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sw = 8'h70;
    miscompares = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_run();
    t_moves();
    t_setpt();
    t_heat_inj();
    t_trips();
    t_remote();
    t_shunt();
    test_done();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule // tb_top

`default_nettype wire
